/* File: verilog/fcs_flash_config.sv */
// Purpose: Flash clock ratio, option copy, config and security control
// Assumes: AXI4-Lite slave on aclk, nonvolatile inputs stable around reset
// Notes: CPU flash writes arrive on a same-clock port; outputs are registered
// How it works
// R1 - Ratio low bits accept only first write
// R2 - Loaded flag set by first ratio write
// R3 - Erase and program blocked until flag set
// R4 - Prescale bit selects bus or bus/8
// R5 - Divider divides by field plus one
// R6 - Software keeps flash clock 150-200 kHz
// R7 - Timing pulse is one flash clock cycle
// R8 - Recommended ratio settings for bus rates
// R9 - Option byte copied in during reset
// R10 - Option bits 5..2 read zero
// R11 - Option register read-only, writes ignored
// R12 - Key disabled or debug source cannot unlock
// R13 - Eight ordered matching bytes unsecure device
// R14 - Redirection disable bit turns redirection off
// R15 - Only code 1:0 means unsecured
// R16 - Secure blocks unsecured source memory access
// R17 - Key match or blank check sets 1:0
// R18 - Config bits 7..5 rw, rest zero
// R19 - Key access steers key-location writes
// R20 - Clearing key access triggers key compare
// R21 - Early erase/program sets access error
// R22 - Divider is counter emitting tick enable
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
module fcs_flash_config (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [fcs_pkg::FCS_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [fcs_pkg::FCS_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] nonvolatile_option_byte,
    input wire logic [8*fcs_pkg::FCS_KEY_BYTES-1:0] backdoor_key_bytes,
    input wire fcs_pkg::fcs_mem_wr_t cpu_wr,
    input wire logic blank_check_pass,
    output logic flash_tick,
    output logic ratio_loaded_flag,
    output logic fclk_range_ok,
    output fcs_pkg::fcs_cmd_t flash_cmd,
    output logic access_error_flag,
    output logic mcu_secure,
    output logic vector_redirect_en,
    output logic key_unlock
);
    // Address decode shared by read and write paths
    function automatic logic [2:0] reg_sel(input logic [fcs_pkg::FCS_ADDR_W-1:0] a);
        reg_sel = {a == fcs_pkg::FCS_OFS_CONFIG,
                   a == fcs_pkg::FCS_OFS_OPTION,
                   a == fcs_pkg::FCS_OFS_RATIO};
    endfunction

    function automatic logic in_key_range(input logic [15:0] a);
        in_key_range = (a[15:fcs_pkg::FCS_KEY_IDX_W] == fcs_pkg::FCS_KEY_BASE_HI);
    endfunction

    // Register state
    logic [6:0] ratio_q;
    logic loaded_q;
    logic [7:0] opt_q;
    logic [1:0] sec_code_q;
    logic [7:0] cfg_q;
    logic key_access_prev_q;

    // AXI state
    logic aw_full_q;
    logic [fcs_pkg::FCS_ADDR_W-1:0] aw_addr_q;
    logic w_full_q;
    logic [7:0] w_data_q;
    logic w_lane_q;

    // Write channel handshakes
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    wire aw_full_d = (aw_full_q || aw_take) && !do_write;
    wire w_full_d = (w_full_q || w_take) && !do_write;
    wire bvalid_d = do_write || (s_axi_bvalid && !s_axi_bready);

    wire [2:0] wsel = reg_sel(aw_addr_q);
    wire wr_hit = |wsel;
    wire wr_lane = do_write && w_lane_q;
    wire ratio_wr = wr_lane && wsel[0];
    wire cfg_wr = wr_lane && wsel[2];

    // Read channel handshakes
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire rvalid_d = ar_take || (s_axi_rvalid && !s_axi_rready);
    wire [2:0] rsel = reg_sel(s_axi_araddr);

    // Readback values
    wire [7:0] ratio_rd = {loaded_q, ratio_q};
    wire [7:0] opt_rd = {opt_q[7:2], sec_code_q} & fcs_pkg::FCS_OPT_USED_MASK; // R10
    wire [7:0] cfg_rd = cfg_q & fcs_pkg::FCS_CFG_RW_MASK; // R18
    wire [7:0] rd_byte = rsel[0] ? ratio_rd :
                         rsel[1] ? opt_rd :
                         rsel[2] ? cfg_rd : 8'h00;

    // Configuration fields
    wire key_access = cfg_q[fcs_pkg::FCS_KEY_ACCESS_BIT];
    wire prescale_by_eight = ratio_q[fcs_pkg::FCS_PRESCALE_BIT];
    wire [fcs_pkg::FCS_DIV_W-1:0] clock_ratio_field = ratio_q[fcs_pkg::FCS_DIV_W-1:0];
    wire backdoor_key_enable = opt_q[fcs_pkg::FCS_KEY_ENABLE_BIT];
    wire redirection_disable = opt_q[fcs_pkg::FCS_NORED_BIT];
    wire key_arm = key_access && !key_access_prev_q;
    wire key_check = !key_access && key_access_prev_q; // R20

    // CPU write steering
    wire key_loc = cpu_wr.valid && in_key_range(cpu_wr.addr);
    wire src_allowed = !mcu_secure || cpu_wr.secure_src; // R16
    wire key_wr_en = key_loc && key_access && cpu_wr.secure_src && !cpu_wr.debug_src; // R12 R19
    wire cmd_try = cpu_wr.valid && !(key_loc && key_access) && src_allowed; // R19
    wire cmd_ok = cmd_try && loaded_q; // R3
    wire cmd_err = cmd_try && !loaded_q; // R21

    // Security code update
    logic key_match;
    wire unlock_evt = key_match || blank_check_pass; // R17
    wire [1:0] sec_code_d = unlock_evt ? fcs_pkg::FCS_SEC_UNSECURED : sec_code_q;
    wire [1:0] nv_sec = nonvolatile_option_byte[1:0];

    // Flash clock period check in bus cycles
    wire [fcs_pkg::FCS_PERIOD_W-1:0] div_plus_one =
        fcs_pkg::FCS_PERIOD_W'(clock_ratio_field) + 1'b1;
    wire [2*fcs_pkg::FCS_PERIOD_W-1:0] period_wide = prescale_by_eight ?
        div_plus_one * fcs_pkg::FCS_PRESCALE_FACTOR :
        (2*fcs_pkg::FCS_PERIOD_W)'(div_plus_one);
    wire [fcs_pkg::FCS_PERIOD_W-1:0] period = period_wide[fcs_pkg::FCS_PERIOD_W-1:0];
    wire range_ok_d = loaded_q && (period >= fcs_pkg::FCS_PULSE_MIN_CYC) &&
        (period <= fcs_pkg::FCS_PULSE_MAX_CYC); // R6 R7 R8

    // AXI write address holding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            s_axi_awready <= !aw_full_d;
            if (aw_take)
            begin
                aw_addr_q <= s_axi_awaddr;
            end
        end
    end

    // AXI write data holding
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_full_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            w_full_q <= w_full_d;
            s_axi_wready <= !w_full_d;
            if (w_take)
            begin
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
        end
    end

    // AXI write response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= fcs_pkg::FCS_RESP_OKAY;
        end
        else
        begin
            s_axi_bvalid <= bvalid_d;
            if (do_write)
            begin
                s_axi_bresp <= wr_hit ? fcs_pkg::FCS_RESP_OKAY : fcs_pkg::FCS_RESP_SLVERR;
            end
        end
    end

    // AXI read path
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= fcs_pkg::FCS_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !rvalid_d;
            s_axi_rvalid <= rvalid_d;
            if (ar_take)
            begin
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= (|rsel) ? fcs_pkg::FCS_RESP_OKAY : fcs_pkg::FCS_RESP_SLVERR;
            end
        end
    end

    // Clock ratio register, written once after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ratio_q <= fcs_pkg::FCS_RATIO_RESET[6:0];
            loaded_q <= fcs_pkg::FCS_RATIO_RESET[fcs_pkg::FCS_RATIO_LOADED_BIT];
        end
        else if (ratio_wr && !loaded_q)
        begin
            ratio_q <= w_data_q[6:0] & fcs_pkg::FCS_RATIO_WR_MASK; // R1
            loaded_q <= 1'b1; // R2
        end
    end

    // Option copy loads during reset; writes have no path here
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            opt_q <= nonvolatile_option_byte & fcs_pkg::FCS_OPT_USED_MASK; // R9 R11
            sec_code_q <= nv_sec;
        end
        else
        begin
            sec_code_q <= sec_code_d; // R17
        end
    end

    // Configuration register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_q <= fcs_pkg::FCS_CFG_RESET;
            key_access_prev_q <= 1'b0;
        end
        else
        begin
            key_access_prev_q <= key_access;
            if (cfg_wr)
            begin
                cfg_q <= w_data_q & fcs_pkg::FCS_CFG_RW_MASK; // R18
            end
        end
    end

    // Command outputs, one-cycle pulses
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flash_cmd <= '0;
            access_error_flag <= 1'b0;
        end
        else
        begin
            flash_cmd.start <= cmd_ok; // R3 R19
            flash_cmd.addr <= cpu_wr.addr;
            flash_cmd.data <= cpu_wr.data;
            access_error_flag <= cmd_err; // R21
        end
    end

    // Ratio status outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ratio_loaded_flag <= 1'b0;
            fclk_range_ok <= 1'b0;
        end
        else
        begin
            ratio_loaded_flag <= loaded_q; // R3
            fclk_range_ok <= range_ok_d;
        end
    end

    // Security outputs; secure and redirect reset values follow the option byte, unlock resets low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mcu_secure <= (nv_sec != fcs_pkg::FCS_SEC_UNSECURED);
            vector_redirect_en <= !nonvolatile_option_byte[fcs_pkg::FCS_NORED_BIT];
            key_unlock <= 1'b0;
        end
        else
        begin
            mcu_secure <= (sec_code_d != fcs_pkg::FCS_SEC_UNSECURED); // R15
            vector_redirect_en <= !redirection_disable; // R14
            key_unlock <= key_match; // R13
        end
    end

    fcs_clk_div u_clk_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(loaded_q),
        .prescale_by_eight(prescale_by_eight),
        .clock_ratio_field(clock_ratio_field),
        .flash_tick(flash_tick)
    );

    fcs_key_cmp u_key_cmp (
        .aclk(aclk),
        .aresetn(aresetn),
        .arm(key_arm),
        .wr_en(key_wr_en),
        .wr_idx(cpu_wr.addr[fcs_pkg::FCS_KEY_IDX_W-1:0]),
        .wr_data(cpu_wr.data),
        .check(key_check),
        .backdoor_key_enable(backdoor_key_enable),
        .backdoor_key_bytes(backdoor_key_bytes),
        .key_match(key_match)
    );
endmodule

/* File: pkg/fcs_pkg.sv */
// Purpose: Shared constants and types for the flash clock/security config block
// Assumes: 20 MHz bus clock, AXI4-Lite register access with 32-bit data
// Notes: Register offsets are byte addresses, one aligned word per register
package fcs_pkg;
    localparam int unsigned FCS_ADDR_W = 8;
    localparam logic [7:0] FCS_OFS_RATIO = 8'h00;
    localparam logic [7:0] FCS_OFS_OPTION = 8'h04;
    localparam logic [7:0] FCS_OFS_CONFIG = 8'h08;
    localparam logic [1:0] FCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] FCS_RESP_SLVERR = 2'h2;

    // Clock ratio register layout
    localparam logic [7:0] FCS_RATIO_RESET = 8'h00;
    localparam int unsigned FCS_RATIO_LOADED_BIT = 7;
    localparam int unsigned FCS_PRESCALE_BIT = 6;
    localparam int unsigned FCS_DIV_W = 6;
    localparam logic [6:0] FCS_RATIO_WR_MASK = 7'h7f;

    // Option register layout
    localparam int unsigned FCS_KEY_ENABLE_BIT = 7;
    localparam int unsigned FCS_NORED_BIT = 6;
    localparam logic [7:0] FCS_OPT_USED_MASK = 8'hc3;
    localparam logic [1:0] FCS_SEC_UNSECURED = 2'h2;

    // Configuration register layout
    localparam logic [7:0] FCS_CFG_RESET = 8'h00;
    localparam logic [7:0] FCS_CFG_RW_MASK = 8'he0;
    localparam int unsigned FCS_KEY_ACCESS_BIT = 5;

    // Prescaler and divider
    localparam int unsigned FCS_PRE_W = 3;
    localparam logic [FCS_PRE_W-1:0] FCS_PRE_LAST = 3'h7;
    localparam int unsigned FCS_PERIOD_W = 10;
    localparam logic [FCS_PERIOD_W-1:0] FCS_PRESCALE_FACTOR = 10'h008;

    // Backdoor key locations
    localparam logic [15:0] FCS_KEY_BASE = 16'hffb0;
    localparam logic [12:0] FCS_KEY_BASE_HI = 13'h1ff6;
    localparam int unsigned FCS_KEY_BYTES = 8;
    localparam int unsigned FCS_KEY_IDX_W = 3;
    localparam logic [3:0] FCS_KEY_COUNT = 4'h8;

    // Flash timing pulse window, as bus cycles per flash clock
    localparam int unsigned FCS_BUS_PERIOD_NS = 50;
    localparam int unsigned FCS_PULSE_MIN_NS = 5000;
    localparam int unsigned FCS_PULSE_MAX_NS = 6700;
    localparam logic [FCS_PERIOD_W-1:0] FCS_PULSE_MIN_CYC =
        FCS_PERIOD_W'((FCS_PULSE_MIN_NS + FCS_BUS_PERIOD_NS - 1) / FCS_BUS_PERIOD_NS);
    localparam logic [FCS_PERIOD_W-1:0] FCS_PULSE_MAX_CYC =
        FCS_PERIOD_W'(FCS_PULSE_MAX_NS / FCS_BUS_PERIOD_NS);

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic [7:0] data;
        logic secure_src;
        logic debug_src;
    } fcs_mem_wr_t;

    typedef struct packed {
        logic start;
        logic [15:0] addr;
        logic [7:0] data;
    } fcs_cmd_t;
endpackage

/* File: verilog/fcs_clk_div.sv */
// Purpose: Flash timing clock enable from bus clock, optional divide by 8
// Assumes: Single bus clock, synchronous active-low reset
// Notes: Output tick is one bus cycle wide, period (divisor+1)*(1 or 8)
module fcs_clk_div (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic prescale_by_eight,
    input wire logic [fcs_pkg::FCS_DIV_W-1:0] clock_ratio_field,
    output logic flash_tick
);
    logic [fcs_pkg::FCS_PRE_W-1:0] pre_q;
    logic [fcs_pkg::FCS_DIV_W-1:0] cnt_q;
    wire pre_tick = (pre_q == fcs_pkg::FCS_PRE_LAST);
    wire src_tick = prescale_by_eight ? pre_tick : 1'b1; // R4
    wire reload = src_tick && (cnt_q == '0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            pre_q <= '0;
            cnt_q <= '0;
            flash_tick <= 1'b0;
        end
        else
        begin
            pre_q <= pre_q + 1'b1;
            flash_tick <= reload; // R22
            if (reload)
            begin
                cnt_q <= clock_ratio_field; // R5
            end
            else if (src_tick)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

/* File: verilog/fcs_key_cmp.sv */
// Purpose: Capture backdoor key bytes and compare against stored key
// Assumes: Byte writes arrive in ascending index order between arm and check
// Notes: Any out-of-order or extra byte spoils the attempt until next arm
module fcs_key_cmp (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arm,
    input wire logic wr_en,
    input wire logic [fcs_pkg::FCS_KEY_IDX_W-1:0] wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic check,
    input wire logic backdoor_key_enable,
    input wire logic [8*fcs_pkg::FCS_KEY_BYTES-1:0] backdoor_key_bytes,
    output logic key_match
);
    logic [7:0] key_q [fcs_pkg::FCS_KEY_BYTES];
    logic [3:0] seq_q;
    logic order_ok_q;
    logic [fcs_pkg::FCS_KEY_BYTES-1:0] byte_eq;

    genvar i;
    generate
        for (i = 0; i < fcs_pkg::FCS_KEY_BYTES; i++)
        begin : g_cmp
            assign byte_eq[i] = (key_q[i] == backdoor_key_bytes[8*i +: 8]);
        end
    endgenerate

    wire in_order = (seq_q < fcs_pkg::FCS_KEY_COUNT) &&
        (wr_idx == seq_q[fcs_pkg::FCS_KEY_IDX_W-1:0]);
    wire all_ok = order_ok_q && (seq_q == fcs_pkg::FCS_KEY_COUNT) && (&byte_eq);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            seq_q <= '0;
            order_ok_q <= 1'b0;
            key_match <= 1'b0;
            for (int k = 0; k < fcs_pkg::FCS_KEY_BYTES; k++)
            begin
                key_q[k] <= 8'h00;
            end
        end
        else
        begin
            key_match <= check && backdoor_key_enable && all_ok; // R13
            if (arm)
            begin
                seq_q <= '0;
                order_ok_q <= 1'b1;
            end
            else if (wr_en)
            begin
                if (in_order) // R13
                begin
                    key_q[wr_idx] <= wr_data;
                    seq_q <= seq_q + 1'b1;
                end
                else
                begin
                    order_ok_q <= 1'b0;
                end
            end
        end
    end
endmodule

/* File: tb/fcs_flash_config_asserts.sv */
// Purpose: Port-level assertions for the flash clock/security config block
// Assumes: One clock aclk, synchronous active-low aresetn
// Notes: Bound onto every fcs_flash_config instance
module fcs_flash_config_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire fcs_pkg::fcs_mem_wr_t cpu_wr,
    input wire logic blank_check_pass,
    input wire logic flash_tick,
    input wire logic ratio_loaded_flag,
    input wire fcs_pkg::fcs_cmd_t flash_cmd,
    input wire logic access_error_flag,
    input wire logic mcu_secure,
    input wire logic vector_redirect_en,
    input wire logic key_unlock
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_err_unloaded: assert property (access_error_flag |->
        $past(cpu_wr.valid) && !ratio_loaded_flag)
        else $error("access error without an early command write");
    a_start_loaded: assert property (flash_cmd.start |->
        ratio_loaded_flag && !access_error_flag)
        else $error("command started while ratio not loaded");
    a_loaded_sticky: assert property (ratio_loaded_flag |=> ratio_loaded_flag)
        else $error("loaded flag dropped without reset");
    a_tick_loaded: assert property (flash_tick |=> ratio_loaded_flag)
        else $error("flash tick before ratio loaded");
    a_unlock_clears: assert property (key_unlock |-> !mcu_secure)
        else $error("key unlock did not unsecure");
    a_blank_unsec: assert property (blank_check_pass |=> !mcu_secure)
        else $error("blank check did not unsecure");
    a_unsec_sticky: assert property (!mcu_secure |=> !mcu_secure)
        else $error("security re-engaged without reset");
    a_redirect_const: assert property ($past(aresetn) |-> $stable(vector_redirect_en))
        else $error("redirect enable changed outside reset");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
        else $error("read answer late or upper bits set");
endmodule

bind fcs_flash_config fcs_flash_config_asserts u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .cpu_wr(cpu_wr), .blank_check_pass(blank_check_pass), .flash_tick(flash_tick),
    .ratio_loaded_flag(ratio_loaded_flag), .flash_cmd(flash_cmd),
    .access_error_flag(access_error_flag), .mcu_secure(mcu_secure),
    .vector_redirect_en(vector_redirect_en), .key_unlock(key_unlock)
);

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the flash clock/security config block
// Assumes: 20 MHz aclk, AXI4-Lite master tasks, same-clock CPU write port
// Notes: Six resets walk security codes, key unlock and blank check paths
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [1:0] OK = fcs_pkg::FCS_RESP_OKAY;
    localparam logic [1:0] ERR = fcs_pkg::FCS_RESP_SLVERR;
    localparam logic [7:0] A_RAT = fcs_pkg::FCS_OFS_RATIO;
    localparam logic [7:0] A_OPT = fcs_pkg::FCS_OFS_OPTION;
    localparam logic [7:0] A_CFG = fcs_pkg::FCS_OFS_CONFIG;
    localparam logic [63:0] KEY = 64'h0123456789abcdef;
    logic aclk, aresetn = 1'b0, blank_check_pass = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, nonvolatile_option_byte = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic flash_tick, ratio_loaded_flag, fclk_range_ok, access_error_flag;
    logic mcu_secure, vector_redirect_en, key_unlock;
    logic [63:0] backdoor_key_bytes = KEY;
    fcs_pkg::fcs_mem_wr_t cpu_wr = '0;
    fcs_pkg::fcs_cmd_t flash_cmd;
    int n_fail = 0;
    int checks = 0;

    fcs_flash_config DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .nonvolatile_option_byte(nonvolatile_option_byte),
        .backdoor_key_bytes(backdoor_key_bytes), .cpu_wr(cpu_wr),
        .blank_check_pass(blank_check_pass), .flash_tick(flash_tick),
        .ratio_loaded_flag(ratio_loaded_flag), .fclk_range_ok(fclk_range_ok),
        .flash_cmd(flash_cmd), .access_error_flag(access_error_flag),
        .mcu_secure(mcu_secure), .vector_redirect_en(vector_redirect_en),
        .key_unlock(key_unlock)
    );

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic hang(input string what);
        n_fail++;
        $display("CHECK FAILED t=%0t timeout %s", $time, what);
        end_of_test();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 50);
        if (!s_axi_bvalid) hang("write");
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "bresp");
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 50);
        if (!s_axi_rvalid) hang("read");
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er, "rresp");
        chk(s_axi_rdata, {24'h0, exp}, "rdata");
    endtask

    // One CPU write; exp is {start, access error}
    task automatic cpu(input logic [15:0] a, input logic [7:0] d, input logic s,
        input logic [1:0] exp);
        @(posedge aclk);
        cpu_wr <= '{1'b1, a, d, s, !s};
        @(posedge aclk);
        cpu_wr.valid <= 1'b0;
        @(negedge aclk);
        chk({flash_cmd.start, access_error_flag}, exp, "cmd or err");
        if (exp[1]) chk({flash_cmd.addr, flash_cmd.data}, {a, d}, "cmd payload");
    endtask

    task automatic do_reset(input logic [7:0] nv);
        @(posedge aclk);
        aresetn <= 1'b0;
        nonvolatile_option_byte <= nv;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
    endtask

    task automatic tick_gap(input int exp);
        int n, g;
        n = 0;
        g = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end
        while (flash_tick !== 1'b1 && n < 2000);
        if (n >= 2000) hang("first tick");
        do
        begin
            @(negedge aclk);
            g++;
        end
        while (flash_tick !== 1'b1 && g < 2000);
        if (g >= 2000) hang("tick");
        chk(g, exp, "tick gap");
    endtask

    // Arm, send eight key bytes (byte bad corrupted; bad 9 sends from debug), disarm
    task automatic key_try(input int bad, input logic exp);
        int n;
        n = 0;
        axi_wr(A_CFG, 8'h20, OK);
        for (int i = 0; i < 8; i++)
            cpu(fcs_pkg::FCS_KEY_BASE + 16'(i), KEY[8*i +: 8] ^ {7'h0, i == bad},
                bad != 9, 2'b00);
        axi_wr(A_CFG, 8'h00, OK);
        do
        begin
            @(negedge aclk);
            n++;
        end
        while (key_unlock !== 1'b1 && n < 10);
        chk(key_unlock, exp, "unlock");
        chk(mcu_secure, !exp, "secure after key");
    endtask

    initial
    begin
        for (int c = 0; c < 4; c++)
        begin
            do_reset(8'(c));
            chk(mcu_secure, c != 2, "secure code");
            axi_rd(A_OPT, 8'(c), OK);
        end
        do_reset(8'hbf);
        chk(vector_redirect_en, 1'b1, "redirect");
        axi_rd(A_OPT, 8'h83, OK);
        axi_rd(A_RAT, 8'h00, OK);
        axi_rd(A_CFG, 8'h00, OK);
        axi_wr(A_OPT, 8'h00, OK);
        axi_rd(A_OPT, 8'h83, OK);
        axi_wr(8'h0c, 8'h55, ERR);
        axi_rd(8'h0c, 8'h00, ERR);
        cpu(16'h1234, 8'h5a, 1'b1, 2'b01);
        axi_wr(A_RAT, 8'h4c, OK);
        axi_rd(A_RAT, 8'hcc, OK);
        chk(ratio_loaded_flag, 1'b1, "loaded");
        axi_wr(A_RAT, 8'h05, OK);
        axi_rd(A_RAT, 8'hcc, OK);
        tick_gap(104);
        chk(fclk_range_ok, 1'b1, "range");
        cpu(16'h1234, 8'h5a, 1'b1, 2'b10);
        cpu(16'h1234, 8'h5a, 1'b0, 2'b00);
        axi_wr(A_CFG, 8'hff, OK);
        axi_rd(A_CFG, 8'he0, OK);
        key_try(3, 1'b0);
        key_try(9, 1'b0);
        key_try(8, 1'b1);
        axi_rd(A_OPT, 8'h82, OK);
        cpu(16'h2000, 8'h11, 1'b0, 2'b10);
        do_reset(8'h40);
        chk(vector_redirect_en, 1'b0, "redirect");
        key_try(8, 1'b0);
        @(posedge aclk);
        blank_check_pass <= 1'b1;
        @(posedge aclk);
        blank_check_pass <= 1'b0;
        repeat (2) @(negedge aclk);
        chk(mcu_secure, 1'b0, "blank unsecure");
        axi_rd(A_OPT, 8'h42, OK);
        axi_wr(A_RAT, 8'h05, OK);
        tick_gap(6);
        chk(fclk_range_ok, 1'b0, "range");
        end_of_test();
    end

    initial
    begin
        repeat (100000) @(posedge aclk);
        hang("run");
    end
endmodule
